// ### rtl/csr_swap_bank.sv
// axi4-lite register bank for compare-swap and bus information quadlets
`timescale 1ns/10ps
`include "csr_swap_regs.svh"

// Notes on behaviour
// - swap data register holds the replacement value until done, then the old value
// - compare register checked against selected resource
// - done flag set when operation finishes
// - any control write clears the done flag
// - select field picks one of four resources
// - control bits thirty to two read zero
// - rom header is read/write first rom quadlet
// - attached serial rom loads the crc field
// - without rom the crc field is undefined until written
// - data and compare undefined until loaded
// - bus identification reads fixed ascii constant
module csr_swap_bank
	import csr_swap_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input  wire logic              clock_i,
	input  wire logic              rst_n_i,
	// axi4-lite write address
	input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
	input  wire logic [2:0]        s_axi_awprot_i,
	input  wire logic              s_axi_awvalid_i,
	output logic                   s_axi_awready_o,
	// axi4-lite write data
	input  wire logic [31:0]       s_axi_wdata_i,
	input  wire logic [3:0]        s_axi_wstrb_i,
	input  wire logic              s_axi_wvalid_i,
	output logic                   s_axi_wready_o,
	// axi4-lite write response
	output logic [1:0]             s_axi_bresp_o,
	output logic                   s_axi_bvalid_o,
	input  wire logic              s_axi_bready_i,
	// axi4-lite read address
	input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
	input  wire logic [2:0]        s_axi_arprot_i,
	input  wire logic              s_axi_arvalid_i,
	output logic                   s_axi_arready_o,
	// axi4-lite read data
	output logic [31:0]            s_axi_rdata_o,
	output logic [1:0]             s_axi_rresp_o,
	output logic                   s_axi_rvalid_o,
	input  wire logic              s_axi_rready_i,
	// serial rom loader, same clock
	input  wire logic              rom_present_i,
	input  wire logic              rom_crc_load_i,
	input  wire logic [15:0]       rom_crc_i,
	// quadlets seen by the link side
	output quadlet_t               rom_header_o,
	output quadlet_t               bus_manager_id_o,
	output quadlet_t               bandwidth_avail_o,
	output quadlet_t               channels_hi_o,
	output quadlet_t               channels_lo_o
);
	generate
		if (ADDR_W < 5) begin : g_bad
			$error("address too narrow for the register map");
		end
	endgenerate

	// byte-lane merge of a write into an old value
	function automatic quadlet_t merge(input quadlet_t old_v,
	                                   input quadlet_t new_v,
	                                   input logic [3:0] strb);
		quadlet_t r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// bus-side state
	logic              aw_pend;    // write address held
	logic              w_pend;     // write data held
	logic [7:0]        aw_addr;    // held write address
	quadlet_t          w_data;     // held write data
	logic [3:0]        w_strb;     // held byte enables
	logic              next_aw_pend;
	logic              next_w_pend;
	logic [7:0]        next_aw_addr;
	quadlet_t          next_w_data;
	logic [3:0]        next_w_strb;
	logic              next_awready;
	logic              next_wready;
	logic              next_bvalid;
	logic [1:0]        next_bresp;
	logic              next_arready;
	logic              next_rvalid;
	quadlet_t          next_rdata;
	logic [1:0]        next_rresp;
	logic              commit;     // write executes this cycle
	logic [7:0]        rd_addr;    // low bits of read address

	// register state
	resource_sel_t     resource_select;      // target of next swap
	logic              swap_complete_flag;   // set on completion
	logic              start;                // launch pulse to engine
	logic [15:0]       hdr_upper;            // info and crc lengths
	logic [15:0]       hdr_crc;              // rom crc, no reset
	quadlet_t          swap_data_value;      // no reset, undefined
	quadlet_t          swap_compare_value;   // no reset, undefined
	resource_sel_t     next_select;
	logic              next_flag;
	logic              next_start;
	logic [15:0]       next_hdr_upper;
	logic [15:0]       next_hdr_crc;
	quadlet_t          next_data;
	quadlet_t          next_compare;
	quadlet_t          merged;     // held write merged over target
	logic              eng_done;   // engine completion pulse
	quadlet_t          eng_old;    // resource value before swap
	quadlet_t          res [4];    // resource values

	assign commit  = aw_pend && w_pend && !s_axi_bvalid_o;
	assign rd_addr = 8'(s_axi_araddr_i);

	// write channels: address and data taken in either order
	always_comb begin
		next_aw_pend = aw_pend;
		next_w_pend  = w_pend;
		next_aw_addr = aw_addr;
		next_w_data  = w_data;
		next_w_strb  = w_strb;
		next_awready = s_axi_awready_o;
		next_wready  = s_axi_wready_o;
		next_bvalid  = s_axi_bvalid_o;
		next_bresp   = s_axi_bresp_o;
		// address handshake, then hold until response done
		if (s_axi_awvalid_i && s_axi_awready_o) begin
			next_aw_pend = 1'b1;
			next_aw_addr = 8'(s_axi_awaddr_i);
			next_awready = 1'b0;
		end
		// data handshake
		if (s_axi_wvalid_i && s_axi_wready_o) begin
			next_w_pend = 1'b1;
			next_w_data = s_axi_wdata_i;
			next_w_strb = s_axi_wstrb_i;
			next_wready = 1'b0;
		end
		// both halves present: execute and answer
		if (commit) begin
			next_aw_pend = 1'b0;
			next_w_pend  = 1'b0;
			next_bvalid  = 1'b1;
			if (aw_addr == `OFS_SWAP_DATA ||
			    aw_addr == `OFS_SWAP_COMPARE ||
			    aw_addr == `OFS_SWAP_CONTROL ||
			    aw_addr == `OFS_ROM_HEADER ||
			    aw_addr == `OFS_BUS_IDENT) begin
				next_bresp = `AXI_RESP_OKAY;
			end else begin
				next_bresp = `AXI_RESP_SLVERR;
			end
		end
		// response taken: reopen both channels
		if (s_axi_bvalid_o && s_axi_bready_i) begin
			next_bvalid  = 1'b0;
			next_awready = 1'b1;
			next_wready  = 1'b1;
		end
	end

	// read channel: data one cycle after the address handshake
	always_comb begin
		next_arready = s_axi_arready_o;
		next_rvalid  = s_axi_rvalid_o;
		next_rdata   = s_axi_rdata_o;
		next_rresp   = s_axi_rresp_o;
		if (s_axi_arvalid_i && s_axi_arready_o) begin
			next_arready = 1'b0;
			next_rvalid  = 1'b1;
			next_rresp   = `AXI_RESP_OKAY;
			if (rd_addr == `OFS_SWAP_DATA) begin
				next_rdata = swap_data_value;
			end else if (rd_addr == `OFS_SWAP_COMPARE) begin
				next_rdata = swap_compare_value;
			end else if (rd_addr == `OFS_SWAP_CONTROL) begin
				// reserved middle bits forced to zero
				next_rdata = {swap_complete_flag, 29'h0,
				              resource_select};
			end else if (rd_addr == `OFS_ROM_HEADER) begin
				next_rdata = {hdr_upper, hdr_crc};
			end else if (rd_addr == `OFS_BUS_IDENT) begin
				next_rdata = `BUS_IDENT_VALUE;
			end else begin
				next_rdata = 32'h0000_0000;
				next_rresp = `AXI_RESP_SLVERR;
			end
		end
		if (s_axi_rvalid_o && s_axi_rready_i) begin
			next_rvalid  = 1'b0;
			next_arready = 1'b1;
		end
	end

	// bus-side flip-flops
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			aw_pend         <= 1'b0;
			w_pend          <= 1'b0;
			aw_addr         <= 8'h00;
			w_data          <= 32'h0000_0000;
			w_strb          <= 4'h0;
			s_axi_awready_o <= 1'b1;
			s_axi_wready_o  <= 1'b1;
			s_axi_bvalid_o  <= 1'b0;
			s_axi_bresp_o   <= `AXI_RESP_OKAY;
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rdata_o   <= 32'h0000_0000;
			s_axi_rresp_o   <= `AXI_RESP_OKAY;
		end else begin
			aw_pend         <= next_aw_pend;
			w_pend          <= next_w_pend;
			aw_addr         <= next_aw_addr;
			w_data          <= next_w_data;
			w_strb          <= next_w_strb;
			s_axi_awready_o <= next_awready;
			s_axi_wready_o  <= next_wready;
			s_axi_bvalid_o  <= next_bvalid;
			s_axi_bresp_o   <= next_bresp;
			s_axi_arready_o <= next_arready;
			s_axi_rvalid_o  <= next_rvalid;
			s_axi_rdata_o   <= next_rdata;
			s_axi_rresp_o   <= next_rresp;
		end
	end

	// control and header next values
	always_comb begin
		next_select    = resource_select;
		next_flag      = swap_complete_flag;
		next_start     = 1'b0;
		next_hdr_upper = hdr_upper;
		next_hdr_crc   = hdr_crc;
		next_data      = swap_data_value;
		next_compare   = swap_compare_value;
		merged         = 32'h0000_0000;
		if (commit && aw_addr == `OFS_SWAP_CONTROL) begin
			// any write clears the flag and launches
			next_flag  = 1'b0;
			next_start = 1'b1;
			if (w_strb[0]) begin
				next_select = resource_sel_t'(
				    w_data[`CTRL_SEL_MSB:`CTRL_SEL_LSB]);
			end
		end
		// completion sets; set wins over a same-cycle clear
		if (eng_done) begin
			next_flag = 1'b1;
			next_data = eng_old;
		end
		if (commit && aw_addr == `OFS_SWAP_DATA) begin
			merged    = merge(swap_data_value, w_data, w_strb);
			next_data = merged;
		end
		if (commit && aw_addr == `OFS_SWAP_COMPARE) begin
			merged       = merge(swap_compare_value, w_data, w_strb);
			next_compare = merged;
		end
		if (commit && aw_addr == `OFS_ROM_HEADER) begin
			merged         = merge({hdr_upper, hdr_crc}, w_data,
			                       w_strb);
			next_hdr_upper = merged[31:16];
			next_hdr_crc   = merged[15:0];
		end
		// serial rom image overrides the crc field when attached
		if (rom_present_i && rom_crc_load_i) begin
			next_hdr_crc = rom_crc_i;
		end
	end

	// control state with a defined reset
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			resource_select    <= SEL_BUS_MANAGER;
			swap_complete_flag <= 1'b0;
			start              <= 1'b0;
			hdr_upper          <= `HDR_UPPER_RESET;
		end else begin
			resource_select    <= next_select;
			swap_complete_flag <= next_flag;
			start              <= next_start;
			hdr_upper          <= next_hdr_upper;
		end
	end

	// data holders deliberately unreset: contents undefined
	// until written, which also saves reset routing
	always_ff @(posedge clock_i) begin
		swap_data_value    <= next_data;
		swap_compare_value <= next_compare;
		hdr_crc            <= next_hdr_crc;
	end

	// header published for remote reads
	always_ff @(posedge clock_i) begin
		rom_header_o <= {next_hdr_upper, next_hdr_crc};
	end

	swap_engine #(
		.NUM_RES   (4),
		.RES_RESET (32'h0000_0000)
	) u_engine (
		.clock_i     (clock_i),
		.rst_n_i     (rst_n_i),
		.start_i     (start),
		.sel_i       (resource_select),
		.compare_i   (swap_compare_value),
		.swap_i      (swap_data_value),
		.done_o      (eng_done),
		.old_value_o (eng_old),
		.res_o       (res)
	);

	assign bus_manager_id_o  = res[0];
	assign bandwidth_avail_o = res[1];
	assign channels_hi_o     = res[2];
	assign channels_lo_o     = res[3];
endmodule // csr_swap_bank

// ### rtl/csr_swap_pkg.sv
// types shared by the compare-swap register bank
package csr_swap_pkg;
	// target of a compare-swap operation
	typedef enum logic [1:0] {
		SEL_BUS_MANAGER  = 2'b00,
		SEL_BANDWIDTH    = 2'b01,
		SEL_CHANNELS_HI  = 2'b10,
		SEL_CHANNELS_LO  = 2'b11
	} resource_sel_t;

	typedef logic [31:0] quadlet_t;
endpackage

// ### rtl/csr_swap_regs.svh
// register offsets, field positions and constants of the compare-swap bank
`ifndef CSR_SWAP_REGS_SVH
`define CSR_SWAP_REGS_SVH

`define OFS_SWAP_DATA      8'h0c
`define OFS_SWAP_COMPARE   8'h10
`define OFS_SWAP_CONTROL   8'h14
`define OFS_ROM_HEADER     8'h18
`define OFS_BUS_IDENT      8'h1c

`define CTRL_DONE_BIT      31
`define CTRL_SEL_LSB       0
`define CTRL_SEL_MSB       1

`define HDR_UPPER_RESET    16'h0000
`define BUS_IDENT_VALUE    32'h31333934

`define AXI_RESP_OKAY      2'b00
`define AXI_RESP_SLVERR    2'b10

`endif

// ### rtl/swap_engine.sv
// the four management resources and their compare-swap datapath
`timescale 1ns/10ps
module swap_engine
	import csr_swap_pkg::*;
#(
	parameter int          NUM_RES   = 4,
	parameter logic [31:0] RES_RESET = 32'h0000_0000
) (
	input  wire logic          clock_i,
	input  wire logic          rst_n_i,
	input  wire logic          start_i,     // one-cycle launch
	input  wire resource_sel_t sel_i,
	input  wire quadlet_t      compare_i,
	input  wire quadlet_t      swap_i,
	output logic               done_o,      // one-cycle completion
	output quadlet_t           old_value_o, // value before the swap
	output quadlet_t           res_o [NUM_RES]
);
	generate
		if (NUM_RES != 4) begin : g_bad
			$error("swap_engine serves exactly four resources");
		end
	endgenerate

	logic     next_done;       // completion pulse next value
	quadlet_t next_old;        // captured prior value
	quadlet_t sel_value;       // currently selected resource

	// the selected resource as seen by the compare
	always_comb begin
		sel_value = res_o[sel_i];
		next_done = start_i;
		next_old  = start_i ? sel_value : old_value_o;
	end

	// per-resource update: only the selected one may change
	genvar g;
	generate
		for (g = 0; g < NUM_RES; g++) begin : g_res
			quadlet_t next_res; // next value of this resource
			always_comb begin
				next_res = res_o[g];
				// swap only on an exact match, else untouched
				if (start_i && (sel_i == 2'(g)) &&
				    (res_o[g] == compare_i)) begin
					next_res = swap_i;
				end
			end
			always_ff @(posedge clock_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					res_o[g] <= RES_RESET;
				end else begin
					res_o[g] <= next_res;
				end
			end
		end
	endgenerate

	// completion pulse and captured old value
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			done_o      <= 1'b0;
			old_value_o <= 32'h0000_0000;
		end else begin
			done_o      <= next_done;
			old_value_o <= next_old;
		end
	end
endmodule // swap_engine

// ### tb/csr_swap_bank_props.sv
// concurrent checks on the ports of the compare-swap register bank
`timescale 1ns/10ps
`include "csr_swap_regs.svh"
module csr_swap_bank_props
	import csr_swap_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input wire logic              clock_i,
	input wire logic              rst_n_i,
	input wire logic              s_axi_awvalid_i,
	input wire logic              s_axi_awready_o,
	input wire logic              s_axi_wvalid_i,
	input wire logic              s_axi_wready_o,
	input wire logic [1:0]        s_axi_bresp_o,
	input wire logic              s_axi_bvalid_o,
	input wire logic              s_axi_bready_i,
	input wire logic [ADDR_W-1:0] s_axi_araddr_i,
	input wire logic              s_axi_arvalid_i,
	input wire logic              s_axi_arready_o,
	input wire logic [31:0]       s_axi_rdata_o,
	input wire logic [1:0]        s_axi_rresp_o,
	input wire logic              s_axi_rvalid_o,
	input wire logic              s_axi_rready_i,
	input wire logic              rom_present_i,
	input wire logic              rom_crc_load_i,
	input wire logic [15:0]       rom_crc_i,
	input wire quadlet_t          rom_header_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	// both write channels taken on one edge
	sequence s_write_taken;
		s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
	endsequence
	// readies drop first, the response comes one cycle later
	sequence s_write_answer;
		!s_axi_awready_o && !s_axi_wready_o ##1 s_axi_bvalid_o;
	endsequence
	// read address taken for a given offset
	sequence s_read_at(logic [ADDR_W-1:0] a);
		s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == a;
	endsequence
	a_write_answer: assert property (s_write_taken |=> s_write_answer)
		else $error("write response not two cycles after handshake");
	a_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i
		|=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
		else $error("write response dropped before bready");
	a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o
		|=> s_axi_rvalid_o && !s_axi_arready_o)
		else $error("read data not one cycle after address");
	a_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i
		|=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
		else $error("read data changed before rready");
	a_bus_ident: assert property (s_read_at(`OFS_BUS_IDENT)
		|=> s_axi_rdata_o == `BUS_IDENT_VALUE)
		else $error("bus identification value wrong");
	a_ctrl_reserved: assert property (s_read_at(`OFS_SWAP_CONTROL)
		|=> s_axi_rdata_o[30:2] == 29'h0)
		else $error("control reserved bits not zero");
	a_unmapped_rd: assert property (s_read_at(8'h40)
		|=> s_axi_rresp_o == `AXI_RESP_SLVERR && s_axi_rdata_o == 32'h0)
		else $error("unmapped read not refused");
	a_crc_load: assert property (rom_present_i && rom_crc_load_i
		|=> rom_header_o[15:0] == $past(rom_crc_i))
		else $error("serial rom crc not loaded");
endmodule // csr_swap_bank_props

bind csr_swap_bank csr_swap_bank_props #(.ADDR_W(ADDR_W)) props (
	.clock_i, .rst_n_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i,
	.s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
	.s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
	.s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .rom_present_i,
	.rom_crc_load_i, .rom_crc_i, .rom_header_o
);

// ### tb/csr_swap_bank_tb.sv
// self-checking bench for the compare-swap register bank
`timescale 1ns/10ps
`include "csr_swap_regs.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module csr_swap_bank_tb import csr_swap_pkg::*; ;
	logic       clock_i = 1'b0, rst_n_i = 1'b0;      // clock, reset
	logic [7:0] s_axi_awaddr_i = 8'h0, s_axi_araddr_i = 8'h0;
	logic [2:0] s_axi_awprot_i = 3'h0, s_axi_arprot_i = 3'h0; // tied
	logic [3:0] s_axi_wstrb_i = 4'hf;                // full words by default
	quadlet_t   s_axi_wdata_i = 32'h0;
	logic       s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0;
	logic       s_axi_bready_i = 1'b0, s_axi_arvalid_i = 1'b0;
	logic       s_axi_rready_i = 1'b0, rom_present_i = 1'b0;
	logic       rom_crc_load_i = 1'b0;
	logic [15:0] rom_crc_i = 16'h0;
	logic       s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
	logic       s_axi_arready_o, s_axi_rvalid_o;
	logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
	quadlet_t   s_axi_rdata_o, rom_header_o, res_now [4];
	quadlet_t   bus_manager_id_o, bandwidth_avail_o, channels_hi_o;
	quadlet_t   channels_lo_o, rd;
	quadlet_t   exp_res [4] = '{default: 32'h0}; // resources reset to 0
	logic [1:0] rr;
	int         fails = 0, compares = 0, i;
	int         stall = 0; // edges before bready or rready may rise

	csr_swap_bank uut (.clock_i, .rst_n_i, .s_axi_awaddr_i, .s_axi_awprot_i,
		.s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i,
		.s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
		.s_axi_bready_i, .s_axi_araddr_i, .s_axi_arprot_i, .s_axi_arvalid_i,
		.s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
		.s_axi_rready_i, .rom_present_i, .rom_crc_load_i, .rom_crc_i,
		.rom_header_o, .bus_manager_id_o, .bandwidth_avail_o, .channels_hi_o,
		.channels_lo_o);

	// resources in select order
	always_comb res_now = '{bus_manager_id_o, bandwidth_avail_o,
		channels_hi_o, channels_lo_o};
	// 40 MHz clock
	always #12.5 clock_i = ~clock_i;

	// counts, verdict, end of run
	task give_verdict;
		$display("counts: %0d compares, %0d fails", compares, fails);
		if (fails == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// a wait that ran out ends the run
	task automatic hang_chk(input int n);
		if (n >= 64) begin
			fails++;
			give_verdict();
		end
	endtask
	// one write; valids and bready hold until taken
	task automatic axi_write(input logic [7:0] a, input quadlet_t d,
		input logic [1:0] er);
		int n;
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= d;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		s_axi_bready_i <= (stall == 0);
		for (n = 0; n < 64; n++) begin
			@(posedge clock_i);
			if (s_axi_awvalid_i && s_axi_awready_o === 1'b1)
				s_axi_awvalid_i <= 1'b0;
			if (s_axi_wvalid_i && s_axi_wready_o === 1'b1)
				s_axi_wvalid_i <= 1'b0;
			if (s_axi_bvalid_o === 1'b1 && s_axi_bready_i)
				break;
			if (n + 1 >= stall)
				s_axi_bready_i <= 1'b1;
		end
		hang_chk(n);
		s_axi_bready_i <= 1'b0;
		`CHK(s_axi_bresp_o, er)
		@(posedge clock_i); // gap so no strobe is set twice in one step
	endtask
	// one read; data taken at the rvalid edge
	task automatic axi_read(input logic [7:0] a, output quadlet_t d,
		output logic [1:0] r);
		int n;
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i <= (stall == 0);
		for (n = 0; n < 64; n++) begin
			@(posedge clock_i);
			if (s_axi_arvalid_i && s_axi_arready_o === 1'b1)
				s_axi_arvalid_i <= 1'b0;
			if (s_axi_rvalid_o === 1'b1 && s_axi_rready_i)
				break;
			if (n + 1 >= stall)
				s_axi_rready_i <= 1'b1;
		end
		hang_chk(n);
		d = s_axi_rdata_o;
		r = s_axi_rresp_o;
		s_axi_rready_i <= 1'b0;
		@(posedge clock_i);
	endtask
	// read and compare data and response
	task automatic rd_chk(input logic [7:0] a, input quadlet_t e,
		input logic [1:0] er);
		axi_read(a, rd, rr);
		`CHK(rd, e)
		`CHK(rr, er)
	endtask
	// full compare-swap as software runs it, with the expected outcome
	task automatic swap_once(input logic [1:0] s, input quadlet_t cmp,
		input quadlet_t sw);
		quadlet_t old;
		int n, k;
		old = exp_res[s];
		axi_write(`OFS_SWAP_DATA, sw, `AXI_RESP_OKAY);
		axi_write(`OFS_SWAP_COMPARE, cmp, `AXI_RESP_OKAY);
		axi_write(`OFS_SWAP_CONTROL, {30'h0, s}, `AXI_RESP_OKAY);
		for (n = 0; n < 16; n++) begin
			axi_read(`OFS_SWAP_CONTROL, rd, rr);
			if (rd[31] === 1'b1)
				break;
		end
		`CHK(rd, {1'b1, 29'h0, s})
		if (old === cmp)
			exp_res[s] = sw; // only a match replaces
		for (k = 0; k < 4; k++)
			`CHK(res_now[k], exp_res[k])
		rd_chk(`OFS_SWAP_DATA, old, `AXI_RESP_OKAY);
	endtask

	// main sequence
	initial begin
		repeat (16) @(posedge clock_i);
		rst_n_i <= 1'b1;
		@(posedge clock_i);
		rd_chk(`OFS_SWAP_CONTROL, 32'h0, `AXI_RESP_OKAY);
		rd_chk(`OFS_BUS_IDENT, `BUS_IDENT_VALUE, `AXI_RESP_OKAY);
		axi_read(`OFS_ROM_HEADER, rd, rr);
		`CHK(rd[31:16], `HDR_UPPER_RESET)
		$display("test reset values done");
		axi_write(`OFS_BUS_IDENT, 32'h0, `AXI_RESP_OKAY);
		rd_chk(`OFS_BUS_IDENT, `BUS_IDENT_VALUE, `AXI_RESP_OKAY);
		axi_write(8'h40, 32'h1, `AXI_RESP_SLVERR);
		rd_chk(8'h40, 32'h0, `AXI_RESP_SLVERR);
		stall = 4; // late bready and rready: answers must stand
		axi_write(`OFS_SWAP_COMPARE, 32'h5555_aaaa, `AXI_RESP_OKAY);
		rd_chk(`OFS_SWAP_COMPARE, 32'h5555_aaaa, `AXI_RESP_OKAY);
		stall = 0;
		s_axi_wstrb_i <= 4'hc; // upper lanes only
		axi_write(`OFS_SWAP_COMPARE, 32'h1234_ffff, `AXI_RESP_OKAY);
		s_axi_wstrb_i <= 4'hf;
		rd_chk(`OFS_SWAP_COMPARE, 32'h1234_aaaa, `AXI_RESP_OKAY);
		$display("test read-only and unmapped done");
		// match from reset, mismatch, then match on a nonzero value
		for (i = 0; i < 4; i++) begin
			swap_once(i[1:0], 32'h0, 32'h1000_00a0 + i);
			swap_once(i[1:0], 32'hffff_0000, 32'h0bad_0000);
			swap_once(i[1:0], 32'h1000_00a0 + i, 32'h2000_0c00 + i);
		end
		// read lands between the clear and the new completion
		fork
			axi_write(`OFS_SWAP_CONTROL, 32'h3, `AXI_RESP_OKAY);
			begin
				repeat (2) @(posedge clock_i);
				rd_chk(`OFS_SWAP_CONTROL, 32'h3, `AXI_RESP_OKAY);
			end
		join
		`CHK(res_now[3], exp_res[3])
		$display("test compare-swap done");
		axi_write(`OFS_ROM_HEADER, 32'h0404_abcd, `AXI_RESP_OKAY);
		rd_chk(`OFS_ROM_HEADER, 32'h0404_abcd, `AXI_RESP_OKAY);
		`CHK(rom_header_o, 32'h0404_abcd)
		// no rom attached: a load strobe must be ignored
		rom_crc_i <= 16'h1111;
		rom_crc_load_i <= 1'b1;
		@(posedge clock_i);
		rom_crc_load_i <= 1'b0;
		rom_present_i <= 1'b1;
		rom_crc_i <= 16'h5a3c;
		@(posedge clock_i);
		`CHK(rom_header_o, 32'h0404_abcd)
		rom_crc_load_i <= 1'b1;
		@(posedge clock_i);
		rom_crc_load_i <= 1'b0;
		rd_chk(`OFS_ROM_HEADER, 32'h0404_5a3c, `AXI_RESP_OKAY);
		$display("test rom header done");
		give_verdict();
	end
endmodule // csr_swap_bank_tb
